// ===== src/plk_lock_ctrl.sv
`timescale 1ns/100ps
module plk_lock_ctrl
    import plk_pkg::*;
#(
    parameter int LOCK_CYCLES = PLK_LOCK_CYCLES
) (
    // system clock and reset
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    // three-wire serial link
    input  wire logic        i_ser_clk,
    input  wire logic        i_ser_data,
    input  wire logic        i_latch_strobe,
    // loop pins, index 0 primary, 1 secondary
    input  wire logic [1:0]  i_ref_div,
    input  wire logic [1:0]  i_prog_div,
    input  wire logic [1:0]  i_loop_pwrdn,
    // charge pump controls
    output logic      [1:0]  o_pump_gain,
    output logic      [1:0]  o_detector_polarity,
    output logic      [1:0]  o_pump_up,
    output logic      [1:0]  o_pump_dn,
    // status
    output logic      [1:0]  o_lock,
    output logic             o_status_out,
    output logic             o_osc_crystal_mode
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (LOCK_CYCLES < 1 || LOCK_CYCLES > 15) begin : g_bad_lock_cycles
        $error("LOCK_CYCLES must lie in 1..15");
    end

    localparam logic [3:0] LOCK_LAST = 4'(LOCK_CYCLES - 1);

    logic [PLK_SHIFT_W-1:0]  link_shift_r;
    logic [PLK_PIN_W-1:0]    pin_sync1_r;
    logic [PLK_PIN_W-1:0]    pin_sync2_r;
    logic [PLK_PIN_W-1:0]    pin_prev_r;
    logic                    latch_rise;
    logic [3:0]              pump_cfg_r;
    logic [3:0]              sel_r;
    logic                    status_r;
    logic                    osc_r;
    logic [1:0]              ref_lvl;
    logic [1:0]              prog_lvl;
    logic [1:0]              pwrdn;
    logic [1:0]              ref_rise;
    logic [1:0]              prog_rise;
    logic [1:0]              pend_r;
    logic [PLK_ERR_W-1:0]    err_cnt_r [2];
    logic [1:0]              pair_done;
    logic [PLK_ERR_W-1:0]    err_val   [2];
    plk_lock_state_type      state_r   [2];
    logic [3:0]              hits_r    [2];
    logic [1:0]              up_r;
    logic [1:0]              dn_r;
    logic [1:0]              up_set;
    logic [1:0]              dn_set;

    ////////////////////////////////////////////////////////////////////////////////
    // link domain: shift in on rising serial clock, msb first so control bits end in [1:0]
    always_ff @(posedge i_ser_clk or posedge i_reset) begin
        if (i_reset) begin
            link_shift_r <= '0;
        end else begin
            link_shift_r <= {link_shift_r[PLK_SHIFT_W-2:0], i_ser_data};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for every pin, plus a third stage for edge detection
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            pin_sync1_r <= '0;
            pin_sync2_r <= '0;
            pin_prev_r  <= '0;
        end else begin
            pin_sync1_r <= {i_latch_strobe, i_loop_pwrdn, i_prog_div, i_ref_div};
            pin_sync2_r <= pin_sync1_r;
            pin_prev_r  <= pin_sync2_r;
        end
    end

    assign latch_rise = pin_sync2_r[PLK_PIN_LATCH] & ~pin_prev_r[PLK_PIN_LATCH];
    assign ref_lvl    = pin_sync2_r[PLK_PIN_REF+1:PLK_PIN_REF];
    assign prog_lvl   = pin_sync2_r[PLK_PIN_PROG+1:PLK_PIN_PROG];
    assign pwrdn      = pin_sync2_r[PLK_PIN_PWRDN+1:PLK_PIN_PWRDN];
    assign ref_rise   = ref_lvl & ~pin_prev_r[PLK_PIN_REF+1:PLK_PIN_REF];
    assign prog_rise  = prog_lvl & ~pin_prev_r[PLK_PIN_PROG+1:PLK_PIN_PROG];

    ////////////////////////////////////////////////////////////////////////////////
    // word load; the shift register is read across domains only after the strobe
    // edge has been synchronised, when the host holds the serial clock still
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            pump_cfg_r <= PLK_CP_RESET;
            sel_r      <= PLK_SEL_RESET;
        end else if (latch_rise) begin
            case (link_shift_r[PLK_WSEL_MSB:PLK_WSEL_LSB])
                PLK_WSEL_MAIN_R: begin
                    pump_cfg_r <= link_shift_r[PLK_FIELD_MSB:PLK_FIELD_LSB];
                end
                PLK_WSEL_AUX_R: begin
                    sel_r <= link_shift_r[PLK_FIELD_MSB:PLK_FIELD_LSB];
                end
                default: begin
                    // divider words belong to the counter block
                end
            endcase
        end
    end

    assign o_pump_gain         = {pump_cfg_r[PLK_CP_SEC_GAIN], pump_cfg_r[PLK_CP_PRI_GAIN]};
    assign o_detector_polarity = {pump_cfg_r[PLK_CP_SEC_POL], pump_cfg_r[PLK_CP_PRI_POL]};

    ////////////////////////////////////////////////////////////////////////////////
    // status pin multiplexer and oscillator buffer mode
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            status_r <= 1'b0;
            osc_r    <= 1'b1;
        end else begin
            case (sel_r[3:1])
                PLK_SEL_LEVEL:     status_r <= sel_r[0];
                PLK_SEL_PRI_LOCK:  status_r <= o_lock[PLK_PRI];
                PLK_SEL_SEC_LOCK:  status_r <= o_lock[PLK_SEC];
                PLK_SEL_BOTH_LOCK: status_r <= o_lock[PLK_PRI] & o_lock[PLK_SEC];
                PLK_SEL_PRI_REF:   status_r <= ref_lvl[PLK_PRI];
                PLK_SEL_SEC_REF:   status_r <= ref_lvl[PLK_SEC];
                PLK_SEL_PRI_PROG:  status_r <= prog_lvl[PLK_PRI];
                PLK_SEL_SEC_PROG:  status_r <= prog_lvl[PLK_SEC];
                default:           status_r <= 1'b0;
            endcase
            // fixed levels need the crystal buffer, otherwise bit 14 chooses
            osc_r <= (sel_r[3:1] == PLK_SEL_LEVEL) ? 1'b1 : sel_r[0];
        end
    end

    assign o_status_out       = status_r;
    assign o_osc_crystal_mode = osc_r;

    ////////////////////////////////////////////////////////////////////////////////
    // per-loop phase error measurement, lock filter and phase-frequency detector
    for (genvar g = 0; g < 2; g++) begin : g_loop

        // one pair closes on the second edge; coincident edges mean zero error
        always_comb begin
            if (pend_r[g]) begin
                pair_done[g] = ref_rise[g] | prog_rise[g];
                err_val[g]   = err_cnt_r[g];
            end else begin
                pair_done[g] = ref_rise[g] & prog_rise[g];
                err_val[g]   = '0;
            end
        end

        // error counter saturates so a missing edge reads as a large error
        always_ff @(posedge i_sys_clk or posedge i_reset) begin
            if (i_reset) begin
                pend_r[g]    <= 1'b0;
                err_cnt_r[g] <= '0;
            end else if (pair_done[g]) begin
                pend_r[g]    <= 1'b0;
                err_cnt_r[g] <= '0;
            end else if (pend_r[g]) begin
                if (err_cnt_r[g] != PLK_ERR_MAX) begin
                    err_cnt_r[g] <= err_cnt_r[g] + 4'h1;
                end
            end else if (ref_rise[g] ^ prog_rise[g]) begin
                pend_r[g]    <= 1'b1;
                err_cnt_r[g] <= 4'h1;
            end
        end

        // lock filter: narrow window to enter, wide window to leave
        always_ff @(posedge i_sys_clk or posedge i_reset) begin
            if (i_reset) begin
                state_r[g] <= PLK_HUNT;
                hits_r[g]  <= '0;
            end else if (pwrdn[g]) begin
                state_r[g] <= PLK_HUNT;
                hits_r[g]  <= '0;
            end else if (pair_done[g]) begin
                case (state_r[g])
                    PLK_HUNT: begin
                        if (err_val[g] <= PLK_NARROW_CYC) begin
                            if (hits_r[g] == LOCK_LAST) begin
                                state_r[g] <= PLK_LOCKED;
                                hits_r[g]  <= '0;
                            end else begin
                                hits_r[g] <= hits_r[g] + 4'h1;
                            end
                        end else begin
                            hits_r[g] <= '0;
                        end
                    end
                    PLK_LOCKED: begin
                        if (err_val[g] > PLK_WIDE_CYC) begin
                            state_r[g] <= PLK_HUNT;
                        end
                    end
                    default: begin
                        state_r[g] <= PLK_HUNT;
                    end
                endcase
            end
        end

        assign o_lock[g] = logic'(state_r[g]);

        // polarity decides which edge pumps up; a falling slope swaps them
        assign up_set[g] = o_detector_polarity[g] ? ref_rise[g] : prog_rise[g];
        assign dn_set[g] = o_detector_polarity[g] ? prog_rise[g] : ref_rise[g];

        // both pulses clear one cycle after they overlap, so a locked loop
        // still shows one-cycle up and down pulses instead of a dead zone
        always_ff @(posedge i_sys_clk or posedge i_reset) begin
            if (i_reset) begin
                up_r[g] <= 1'b0;
                dn_r[g] <= 1'b0;
            end else if (pwrdn[g] || (up_r[g] && dn_r[g])) begin
                up_r[g] <= 1'b0;
                dn_r[g] <= 1'b0;
            end else begin
                up_r[g] <= up_r[g] | up_set[g];
                dn_r[g] <= dn_r[g] | dn_set[g];
            end
        end

        assign o_pump_up[g] = up_r[g];
        assign o_pump_dn[g] = dn_r[g];

        // lock filter and pump pulse checks
        property p_lock_entry;
            @(posedge i_sys_clk) disable iff (i_reset)
            $rose(o_lock[g]) |-> $past(pair_done[g] && err_val[g] <= PLK_NARROW_CYC && hits_r[g] == LOCK_LAST);
        endproperty
        a_lock_entry: assert property (p_lock_entry) else $error("lock rose without enough good cycles");

        property p_lock_exit;
            @(posedge i_sys_clk) disable iff (i_reset)
            o_lock[g] && !pwrdn[g] && pair_done[g] && err_val[g] > PLK_WIDE_CYC |=> !o_lock[g];
        endproperty
        a_lock_exit: assert property (p_lock_exit) else $error("lock held past wide window");

        property p_lock_hold;
            @(posedge i_sys_clk) disable iff (i_reset)
            $fell(o_lock[g]) |-> $past(pwrdn[g] || (pair_done[g] && err_val[g] > PLK_WIDE_CYC));
        endproperty
        a_lock_hold: assert property (p_lock_hold) else $error("lock fell inside wide window");

        property p_pwrdn;
            @(posedge i_sys_clk) disable iff (i_reset)
            pwrdn[g] |=> !o_lock[g] && hits_r[g] == 4'h0;
        endproperty
        a_pwrdn: assert property (p_pwrdn) else $error("lock not forced low in power-down");

        property p_restart;
            @(posedge i_sys_clk) disable iff (i_reset)
            !o_lock[g] && !pwrdn[g] && pair_done[g] && err_val[g] > PLK_NARROW_CYC |=> hits_r[g] == 4'h0 && !o_lock[g];
        endproperty
        a_restart: assert property (p_restart) else $error("bad cycle did not restart count");

        property p_min_pulse;
            @(posedge i_sys_clk) disable iff (i_reset)
            !pwrdn[g] && !up_r[g] && !dn_r[g] && up_set[g] && dn_set[g] |=> up_r[g] && dn_r[g] ##1 !up_r[g] && !dn_r[g];
        endproperty
        a_min_pulse: assert property (p_min_pulse) else $error("locked edges gave no minimum pulse");

        c_lock: cover property (@(posedge i_sys_clk) disable iff (i_reset) $rose(o_lock[g]));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // load, mux and link checks
    property p_load_gain;
        @(posedge i_sys_clk) disable iff (i_reset)
        latch_rise && link_shift_r[PLK_WSEL_MSB:PLK_WSEL_LSB] == PLK_WSEL_MAIN_R
            |=> o_pump_gain == {$past(link_shift_r[PLK_FIELD_MSB]), $past(link_shift_r[PLK_FIELD_MSB-1])};
    endproperty
    a_load_gain: assert property (p_load_gain) else $error("gain bits not taken from 17 and 16");

    property p_load_pol;
        @(posedge i_sys_clk) disable iff (i_reset)
        latch_rise && link_shift_r[PLK_WSEL_MSB:PLK_WSEL_LSB] == PLK_WSEL_MAIN_R
            |=> o_detector_polarity == {$past(link_shift_r[PLK_FIELD_LSB+1]), $past(link_shift_r[PLK_FIELD_LSB])};
    endproperty
    a_load_pol: assert property (p_load_pol) else $error("polarity bits not taken from 15 and 14");

    property p_load_sel;
        @(posedge i_sys_clk) disable iff (i_reset)
        latch_rise && link_shift_r[PLK_WSEL_MSB:PLK_WSEL_LSB] != PLK_WSEL_AUX_R |=> $stable(sel_r);
    endproperty
    a_load_sel: assert property (p_load_sel) else $error("select changed on a foreign word");

    property p_sel_level;
        @(posedge i_sys_clk) disable iff (i_reset)
        sel_r[3:1] == PLK_SEL_LEVEL |=> o_status_out == $past(sel_r[0]) && o_osc_crystal_mode;
    endproperty
    a_sel_level: assert property (p_sel_level) else $error("fixed level or crystal force wrong");

    property p_sel_both;
        @(posedge i_sys_clk) disable iff (i_reset)
        sel_r[3:1] == PLK_SEL_BOTH_LOCK |=> o_status_out == ($past(o_lock[PLK_PRI]) && $past(o_lock[PLK_SEC]));
    endproperty
    a_sel_both: assert property (p_sel_both) else $error("status pin not the and of both locks");

    property p_sel_div;
        @(posedge i_sys_clk) disable iff (i_reset)
        sel_r[3:1] == PLK_SEL_SEC_PROG |=> o_status_out == $past(prog_lvl[PLK_SEC]);
    endproperty
    a_sel_div: assert property (p_sel_div) else $error("status pin not the aux programmable divider");

    property p_osc_mode;
        @(posedge i_sys_clk) disable iff (i_reset)
        sel_r[3:1] != PLK_SEL_LEVEL |=> o_osc_crystal_mode == $past(sel_r[0]);
    endproperty
    a_osc_mode: assert property (p_osc_mode) else $error("buffer mode not bit 14");

    property p_shift;
        @(posedge i_ser_clk) disable iff (i_reset)
        1'b1 |=> link_shift_r[0] == $past(i_ser_data) && link_shift_r[PLK_SHIFT_W-1:1] == $past(link_shift_r[PLK_SHIFT_W-2:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("serial bit not shifted in");

    c_load_main: cover property (@(posedge i_sys_clk) disable iff (i_reset)
        latch_rise && link_shift_r[PLK_WSEL_MSB:PLK_WSEL_LSB] == PLK_WSEL_MAIN_R);
    c_status_high: cover property (@(posedge i_sys_clk) disable iff (i_reset) sel_r == 4'h1 ##1 o_status_out);
    c_logic_mode: cover property (@(posedge i_sys_clk) disable iff (i_reset) !o_osc_crystal_mode);

endmodule

// ===== src/plk_pkg.sv
package plk_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // serial word layout
    localparam int          PLK_SHIFT_W     = 18;
    localparam int          PLK_FIELD_MSB   = 17;   // top of the four-bit control field
    localparam int          PLK_FIELD_LSB   = 14;   // bottom of the four-bit control field
    localparam int          PLK_WSEL_MSB    = 1;
    localparam int          PLK_WSEL_LSB    = 0;
    localparam logic [1:0]  PLK_WSEL_AUX_R  = 2'h0;
    localparam logic [1:0]  PLK_WSEL_AUX_N  = 2'h1;
    localparam logic [1:0]  PLK_WSEL_MAIN_R = 2'h2;
    localparam logic [1:0]  PLK_WSEL_MAIN_N = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // charge_pump_control_word bit positions (inside the four-bit field)
    localparam int          PLK_CP_SEC_GAIN = 3;
    localparam int          PLK_CP_PRI_GAIN = 2;
    localparam int          PLK_CP_SEC_POL  = 1;
    localparam int          PLK_CP_PRI_POL  = 0;
    localparam logic [3:0]  PLK_CP_RESET    = 4'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // status_output_select codes, upper three bits
    localparam logic [3:0]  PLK_SEL_RESET     = 4'h0;
    localparam logic [2:0]  PLK_SEL_LEVEL     = 3'h0;
    localparam logic [2:0]  PLK_SEL_PRI_LOCK  = 3'h1;
    localparam logic [2:0]  PLK_SEL_SEC_LOCK  = 3'h2;
    localparam logic [2:0]  PLK_SEL_BOTH_LOCK = 3'h3;
    localparam logic [2:0]  PLK_SEL_PRI_REF   = 3'h4;
    localparam logic [2:0]  PLK_SEL_SEC_REF   = 3'h5;
    localparam logic [2:0]  PLK_SEL_PRI_PROG  = 3'h6;
    localparam logic [2:0]  PLK_SEL_SEC_PROG  = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // loop indices and pin sync vector layout
    localparam int          PLK_PRI         = 0;
    localparam int          PLK_SEC         = 1;
    localparam int          PLK_PIN_REF     = 0;    // bits 1:0
    localparam int          PLK_PIN_PROG    = 2;    // bits 3:2
    localparam int          PLK_PIN_PWRDN   = 4;    // bits 5:4
    localparam int          PLK_PIN_LATCH   = 6;
    localparam int          PLK_PIN_W       = 7;

    ////////////////////////////////////////////////////////////////////////////////
    // lock detector timing
    localparam int          PLK_SYS_CLK_NS  = 4;
    localparam int          PLK_NARROW_NS   = 15;
    localparam int          PLK_WIDE_NS     = 30;
    localparam int          PLK_ERR_W       = 4;
    localparam logic [3:0]  PLK_NARROW_CYC  = 4'(PLK_NARROW_NS / PLK_SYS_CLK_NS);  // rounds down
    localparam logic [3:0]  PLK_WIDE_CYC    = 4'(PLK_WIDE_NS / PLK_SYS_CLK_NS);    // rounds down
    localparam logic [3:0]  PLK_ERR_MAX     = 4'hF;
    localparam int          PLK_LOCK_CYCLES = 4;

    typedef enum logic {
        PLK_HUNT   = 1'b0,
        PLK_LOCKED = 1'b1
    } plk_lock_state_type;

endpackage

// ===== testbench/plk_host_model.sv
`timescale 1ns/100ps
// host end of the three-wire link; the serial clock only runs inside a word
module plk_host_model (
    // free-running link clock
    input  wire logic i_link_clk,
    // serial pins toward the block
    output logic      o_ser_clk,
    output logic      o_ser_data,
    output logic      o_latch_strobe
);
    logic gate_r = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // gating in the low phase keeps runt pulses off the serial clock
    assign o_ser_clk = gate_r & i_link_clk;
    initial begin
        o_ser_data     = 1'b0;
        o_latch_strobe = 1'b0;
    end
    // data moves on falling edges so it is steady around each rising edge
    task automatic send(input logic [17:0] word);
        for (int i = 17; i >= 0; i--) begin
            @(negedge i_link_clk);
            o_ser_data <= word[i];
            gate_r     <= 1'b1;
        end
        @(negedge i_link_clk);
        gate_r     <= 1'b0;
        o_ser_data <= ~word[0]; // released line must not look like the last bit
        @(negedge i_link_clk);
        o_latch_strobe <= 1'b1;
        repeat (2) @(negedge i_link_clk);
        o_latch_strobe <= 1'b0;
        repeat (2) @(negedge i_link_clk);
    endtask
endmodule

// ===== testbench/test_pll_ctrl_lock_detect_mux.sv
`timescale 1ns/100ps
module test_pll_ctrl_lock_detect_mux
    import plk_pkg::*;
;
    typedef struct packed {
        int         what;
        logic [3:0] exp;
    } plk_note_type;
    logic         sys_clk  = 1'b0;
    logic         link_clk = 1'b0;
    logic         reset    = 1'b1;
    logic         ser_clk, ser_data, latch;
    logic [1:0]   ref_div  = 2'h0;
    logic [1:0]   prog_div = 2'h0;
    logic [1:0]   pwrdn    = 2'h0;
    logic [1:0]   gain, pol, up, dn, lock;
    logic         status, osc;
    int           bad_count = 0;
    int           cmp_count = 0;
    int           both_cnt  = 0;
    int           seed      = 32'he545;
    plk_note_type notes[$];
    logic [3:0]   f;
    string        nm[7] = '{"gain", "polarity", "lock", "status", "osc_mode", "pump_overlap", "pump_dir"};
    ////////////////////////////////////////////////////////////////////////////////
    // clocks; link clock phase is offset on purpose
    always #2 sys_clk = ~sys_clk;
    initial #1.3 forever #7.5 link_clk = ~link_clk;
    plk_lock_ctrl dut (.i_sys_clk(sys_clk), .i_reset(reset), .i_ser_clk(ser_clk), .i_ser_data(ser_data),
        .i_latch_strobe(latch), .i_ref_div(ref_div), .i_prog_div(prog_div), .i_loop_pwrdn(pwrdn),
        .o_pump_gain(gain), .o_detector_polarity(pol), .o_pump_up(up), .o_pump_dn(dn), .o_lock(lock),
        .o_status_out(status), .o_osc_crystal_mode(osc));
    plk_host_model host (.i_link_clk(link_clk), .o_ser_clk(ser_clk), .o_ser_data(ser_data),
        .o_latch_strobe(latch));
    ////////////////////////////////////////////////////////////////////////////////
    // cycles where both primary pumps are on at once
    always @(posedge sys_clk) begin
        if (up[0] === 1'b1 && dn[0] === 1'b1) both_cnt++;
    end
    function automatic logic [3:0] seen(int w);
        case (w)
            0: seen = {2'h0, gain};
            1: seen = {2'h0, pol};
            2: seen = {2'h0, lock};
            3: seen = {3'h0, status};
            4: seen = {3'h0, osc};
            5: seen = 4'(both_cnt);
            default: seen = {up, dn};
        endcase
    endfunction
    // monitor: every queued note against the outputs, oldest first, half a cycle after they settle
    always @(negedge sys_clk) begin
        while (notes.size() > 0) begin
            plk_note_type n;
            n = notes.pop_front();
            cmp_count++;
            if (seen(n.what) !== n.exp) begin
                bad_count++;
                $display("[FAIL] %s expected %h seen %h", nm[n.what], n.exp, seen(n.what));
            end
        end
    end
    task automatic note(int w, logic [3:0] e);
        notes.push_back('{w, e});
    endtask
    // one measurement on both loops, prog edges err cycles after ref edges;
    // from err 3 on the ref edge has set its pump before the prog edge lands
    task automatic pair(int err);
        ref_div <= 2'b11;
        repeat (err) @(posedge sys_clk);
        prog_div <= 2'b11;
        if (err >= 3) note(6, {f[1:0], ~f[1:0]});
        repeat (4) @(posedge sys_clk);
        ref_div  <= 2'b00;
        prog_div <= 2'b00;
        repeat (10) @(posedge sys_clk);
    endtask
    task automatic word(logic [3:0] f, logic [1:0] ctl);
        host.send({f, 12'h5A3, ctl});
        repeat (10) @(posedge sys_clk);
    endtask
    task automatic give_verdict;
        if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // watchdog, well past the expected run length
    initial begin
        #100000;
        bad_count++;
        $display("[FAIL] watchdog expected done seen hang");
        give_verdict;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [2:0] c;
        logic [7:0] pick;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        for (int w = 0; w < 5; w++) note(w, 4'(w == 4));
        // random pump fields; divider words in between must not disturb them
        for (int i = 0; i < 4; i++) begin
            f = 4'($random(seed));
            word(f, PLK_WSEL_MAIN_R);
            note(0, {2'h0, f[3:2]});
            note(1, {2'h0, f[1:0]});
            word(~f, i[0] ? PLK_WSEL_AUX_N : PLK_WSEL_MAIN_N);
            note(0, {2'h0, f[3:2]});
        end
        // three coincident edges give three one-cycle overlaps, then a bad one
        repeat (3) pair(0);
        note(5, 4'h3);
        pair(4);
        note(2, 4'h0);
        repeat (3) pair(3);
        note(2, 4'h0);
        pair(3);
        note(2, 4'h3);
        pair(7);
        note(2, 4'h3);
        pair(8);
        note(2, 4'h0);
        repeat (4) pair(0);
        note(2, 4'h3);
        // static divider levels so every select code has a known answer
        ref_div  <= 2'b01;
        prog_div <= 2'b10;
        for (int s = 0; s < 16; s++) begin
            word(4'(s), PLK_WSEL_AUX_R);
            c = 3'(s >> 1);
            pick = {prog_div[1], prog_div[0], ref_div[1], ref_div[0], 3'b111, 1'(s)};
            note(3, {3'h0, pick[c]});
            note(4, (c == 3'h0) ? 4'h1 : 4'(s & 1));
        end
        // primary loop down, secondary still locked, so the lock codes differ
        pwrdn <= 2'b01;
        repeat (6) @(posedge sys_clk);
        note(2, 4'h2);
        for (int s = 2; s < 8; s += 2) begin
            word(4'(s), PLK_WSEL_AUX_R);
            note(3, 4'(s == 4));
        end
        repeat (2) @(posedge sys_clk);
        give_verdict;
    end
endmodule
